/* hdl/rmh_host_pins.sv */
// host pin interface of a hopping radio module with a register slave
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - command_response_flag_n is low while serial output carries a reply.
// - payload from the air and command replies share one serial output.
// - exception_out goes high for an exception only if its mask bit is set.
// - serial bytes are commands while select is low, payload while high.
// - a low sleep request puts the block in a non-functional low power state.
// - the block is held in reset while its reset input is low.
// - rx_amp_enable is high while the radio receives.
// - tx_amp_enable is high while the radio transmits.
// - ctsN is low when input can be taken and high while busy.
// - tx_buffer_empty is high once every queued input byte has been sent.
// - with acknowledge on, empty waits for the ack or a retry exception.
// - activity_indicator flashes with a length set by the operating state.
// - button press lengths restore defaults or start a network join.
module rmh_host_pins #(
    parameter logic [15:0] BIT_CYC  = rmh_pkg::BIT_CYC_DEF,
    parameter logic [31:0] REL_CYC  = rmh_pkg::REL_CYC_DEF,
    parameter logic [31:0] BTN_DEB  = rmh_pkg::BTN_DEB_DEF,
    parameter logic [31:0] BTN_LONG = rmh_pkg::BTN_LONG_DEF,
    parameter logic [31:0] LED_CMD  = rmh_pkg::LED_CMD_DEF,
    parameter logic [31:0] LED_DATA = rmh_pkg::LED_DATA_DEF
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq,
    input  wire logic              serialIn,
    output logic                   serialOut,
    input  wire logic              dataModeSel,
    input  wire logic              sleepReqN,
    input  wire logic              button_input,
    output logic                   ctsN,
    output logic                   tx_buffer_empty,
    output logic                   command_response_flag_n,
    output logic                   exception_out,
    output logic                   rx_amp_enable,
    output logic                   tx_amp_enable,
    output logic                   activity_indicator,
    output rmh_pkg::rmh_byte_t     radioTxByte,
    input  wire logic              radioTxReady,
    output logic                   txFlush,
    input  wire rmh_pkg::rmh_byte_t radioRxByte,
    output logic                   radioRxReady,
    input  wire logic              radioTxActive,
    input  wire logic              radioRxActive,
    input  wire logic              radioAck,
    input  wire logic              radioRetryFail,
    output logic                   restoreDefaults,
    output logic                   joinNetwork,
    output logic                   lowPower
);
    import rmh_pkg::*;

    // sticky status update: a hardware set wins over a write-one clear
    function automatic logic [7:0] stickyNext(input logic [7:0] cur,
                                              input logic [7:0] set,
                                              input logic [7:0] clr);
        stickyNext = set | (cur & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flip-flops each
    logic [3:0]  pinMeta;
    logic [3:0]  pinSync;
    logic        serialS;
    logic        selS;
    logic        awakeS;
    logic        buttonS;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinMeta <= PIN_RST;
            pinSync <= PIN_RST;
        end else begin
            pinMeta <= {button_input, sleepReqN, dataModeSel, serialIn};
            pinSync <= pinMeta;
        end
    end
    assign serialS = pinSync[0];
    assign selS    = pinSync[1];
    assign awakeS  = pinSync[2];
    assign buttonS = pinSync[3];

    ////////////////////////////////////////////////////////////////////////////
    // register state and bus slave
    logic [2:0]       ctrl;
    logic [EXC_W-1:0] excMask;
    logic [EXC_W-1:0] excStatus;
    logic [EV_W-1:0]  irqMask;
    logic [EV_W-1:0]  irqStatus;
    rmh_byte_t        cmdByte;
    rmh_byte_t        replyByte;
    logic             busWr;
    logic             busRd;
    logic [EXC_W-1:0] excSet;
    logic [EV_W-1:0]  evSet;
    logic             ackWait;
    logic             txBusy;
    assign busWr = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign busRd = avs_read && !avs_waitrequest;

    // waitrequest drops for one cycle, one edge after a request is seen
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    OFS_CTRL:    avs_readdata <= {29'h0, ctrl};
                    OFS_STATUS:  avs_readdata <= {22'h0, ackWait, txBusy,
                        !awakeS, selS, ctsN, tx_buffer_empty,
                        command_response_flag_n, radioTxByte.valid,
                        radioRxActive, radioTxActive};
                    OFS_CMDRX:   avs_readdata <= {23'h0, cmdByte};
                    OFS_EXCMASK: avs_readdata <= {28'h0, excMask};
                    OFS_EXCSTAT: avs_readdata <= {28'h0, excStatus};
                    OFS_IRQSTAT: avs_readdata <= {26'h0, irqStatus};
                    OFS_IRQMASK: avs_readdata <= {26'h0, irqMask};
                    default:     avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // software-written control and masks
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl    <= CTRL_RST;
            excMask <= '0;
            irqMask <= '0;
        end else if (busWr) begin
            if (avs_address == OFS_CTRL) ctrl <= avs_writedata[2:0];
            if (avs_address == OFS_EXCMASK) excMask <= avs_writedata[3:0];
            if (avs_address == OFS_IRQMASK) irqMask <= avs_writedata[5:0];
        end
    end

    // sticky exception and interrupt status, write one to clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            excStatus     <= '0;
            irqStatus     <= '0;
            exception_out <= 1'b0;
            irq           <= 1'b0;
        end else begin
            excStatus <= EXC_W'(stickyNext(8'(excStatus), 8'(excSet),
                (busWr && avs_address == OFS_EXCSTAT) ?
                avs_writedata[7:0] : 8'h0));
            irqStatus <= EV_W'(stickyNext(8'(irqStatus), 8'(evSet),
                (busWr && avs_address == OFS_IRQSTAT) ?
                avs_writedata[7:0] : 8'h0));
            exception_out <= |(excStatus & excMask);
            irq           <= |(irqStatus & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // uart receiver, sampled mid-bit
    logic        rxBusy;
    logic [15:0] rxCnt;
    logic [3:0]  rxBit;
    logic [8:0]  rxShift;
    logic        rxDone;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxBusy  <= 1'b0;
            rxCnt   <= 16'h0;
            rxBit   <= 4'h0;
            rxShift <= 9'h0;
            rxDone  <= 1'b0;
        end else begin
            rxDone <= 1'b0;
            if (!rxBusy) begin
                if (!serialS && awakeS) begin
                    rxBusy <= 1'b1;
                    rxCnt  <= BIT_CYC >> 1;
                    rxBit  <= 4'h0;
                end
            end else if (rxCnt != 16'h0) begin
                rxCnt <= rxCnt - 16'h1;
            end else begin
                rxCnt <= BIT_CYC - 16'h1;
                rxBit <= rxBit + 4'h1;
                if (rxBit == 4'h0 && serialS) rxBusy <= 1'b0; // false start
                if (rxBit != 4'h0) rxShift <= {serialS, rxShift[8:1]};
                if (rxBit == UART_FRAME_BITS - 4'h1) begin
                    rxBusy <= 1'b0;
                    rxDone <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing of received bytes, flow control and buffer empty
    logic goodByte;
    logic txTaken;
    logic nextEmpty;
    assign goodByte  = rxDone && rxShift[8];
    assign txTaken   = radioTxByte.valid && radioTxReady;
    assign nextEmpty = !radioTxByte.valid && !radioTxActive && !ackWait;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            radioTxByte     <= '0;
            cmdByte         <= '0;
            ackWait         <= 1'b0;
            ctsN            <= 1'b1;
            tx_buffer_empty <= 1'b1;
        end else begin
            if (txTaken) radioTxByte.valid <= 1'b0;
            if (busRd && avs_address == OFS_CMDRX) cmdByte.valid <= 1'b0;
            if (goodByte && selS && !radioTxByte.valid) begin
                radioTxByte <= '{valid: 1'b1, data: rxShift[7:0]};
            end
            if (goodByte && !selS && !cmdByte.valid) begin
                cmdByte <= '{valid: 1'b1, data: rxShift[7:0]};
            end
            if (txTaken && ctrl[CTRL_ACK]) begin
                ackWait <= 1'b1;
            end else if (radioAck || radioRetryFail) begin
                ackWait <= 1'b0;
            end
            ctsN <= !awakeS || radioTxByte.valid || cmdByte.valid;
            tx_buffer_empty <= nextEmpty;
        end
    end

    // exception and interrupt event sources
    always_comb begin
        excSet = '0;
        excSet[EXC_RETRY]   = radioRetryFail;
        excSet[EXC_FRAME]   = rxDone && !rxShift[8];
        excSet[EXC_OVERRUN] = goodByte &&
            (selS ? radioTxByte.valid : cmdByte.valid);
        excSet[EXC_SW]      = ctrl[CTRL_SW_EXC];
        evSet = '0;
        evSet[EV_CMD]      = goodByte && !selS && !cmdByte.valid;
        evSet[EV_JOIN]     = joinNetwork;
        evSet[EV_DEFAULTS] = restoreDefaults;
        evSet[EV_RELEASE]  = txFlush;
        evSet[EV_EXC]      = |(excSet & excMask & ~excStatus);
        evSet[EV_EMPTY]    = nextEmpty && !tx_buffer_empty;
    end

    ////////////////////////////////////////////////////////////////////////////
    // uart transmitter shared by replies and air payload
    logic [15:0] baudCnt;
    logic        baudTick;
    logic [9:0]  txShift;
    logic [3:0]  txBit;
    logic        txIsReply;
    logic [3:0]  holdBits;
    logic        loadReply;
    logic        loadRadio;
    assign loadReply = !txBusy && replyByte.valid && awakeS;
    assign loadRadio = !txBusy && !replyByte.valid && radioRxReady
        && radioRxByte.valid;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            baudCnt  <= 16'h0;
            baudTick <= 1'b0;
        end else begin
            baudTick <= (baudCnt == 16'h0);
            baudCnt  <= (baudCnt == 16'h0) ? BIT_CYC - 16'h1 : baudCnt - 16'h1;
        end
    end

    // reply byte holding register, written by software
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            replyByte <= '0;
        end else if (busWr && avs_address == OFS_REPLY) begin
            replyByte <= '{valid: 1'b1, data: avs_writedata[7:0]};
        end else if (loadReply) begin
            replyByte.valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txBusy                  <= 1'b0;
            txShift                 <= 10'h3ff;
            txBit                   <= 4'h0;
            txIsReply               <= 1'b0;
            holdBits                <= 4'h0;
            serialOut               <= 1'b1;
            radioRxReady            <= 1'b0;
            command_response_flag_n <= 1'b1;
        end else begin
            radioRxReady <= !txBusy && !loadRadio && !replyByte.valid
                && awakeS && holdBits == 4'h0;
            if (loadReply) begin
                txBusy                  <= 1'b1;
                txShift                 <= {1'b1, replyByte.data, 1'b0};
                txBit                   <= 4'h0;
                txIsReply               <= 1'b1;
                holdBits                <= 4'h0;
                command_response_flag_n <= 1'b0;
            end else if (loadRadio) begin
                txBusy    <= 1'b1;
                txShift   <= {1'b1, radioRxByte.data, 1'b0};
                txBit     <= 4'h0;
                txIsReply <= 1'b0;
            end else if (baudTick && txBusy) begin
                if (txBit == UART_FRAME_BITS) begin
                    txBusy <= 1'b0;
                    if (txIsReply) holdBits <= COMMAND_RESPONSE_FLAG_N_HOLD_BITS;
                end else begin
                    serialOut <= txShift[0];
                    txShift   <= {1'b1, txShift[9:1]};
                    txBit     <= txBit + 4'h1;
                end
            end else if (baudTick && holdBits != 4'h0) begin
                holdBits <= holdBits - 4'h1;
                if (holdBits == 4'h1) command_response_flag_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // release trigger, button decoding, sleep and amplifier enables
    logic [31:0] relCnt;
    logic [31:0] btnCnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            relCnt          <= 32'h0;
            txFlush         <= 1'b0;
            btnCnt          <= 32'h0;
            restoreDefaults <= 1'b0;
            joinNetwork     <= 1'b0;
        end else begin
            txFlush <= 1'b0;
            if (selS || !ctrl[CTRL_REL] || !awakeS) relCnt <= 32'h0;
            else if (relCnt != REL_CYC) relCnt <= relCnt + 32'h1;
            if (relCnt == REL_CYC - 32'h1) txFlush <= 1'b1;
            restoreDefaults <= 1'b0;
            joinNetwork     <= 1'b0;
            if (buttonS && awakeS) begin
                if (btnCnt != BTN_LONG) btnCnt <= btnCnt + 32'h1;
            end else begin
                btnCnt <= 32'h0;
                restoreDefaults <= (btnCnt == BTN_LONG);
                joinNetwork <= (btnCnt >= BTN_DEB) && (btnCnt != BTN_LONG);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lowPower      <= 1'b0;
            rx_amp_enable <= 1'b0;
            tx_amp_enable <= 1'b0;
        end else begin
            lowPower      <= !awakeS;
            rx_amp_enable <= radioRxActive && awakeS;
            tx_amp_enable <= radioTxActive && awakeS;
        end
    end

    // activity flash, long in command mode, short in data mode
    logic [31:0] ledCnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ledCnt             <= 32'h0;
            activity_indicator <= 1'b0;
        end else begin
            if (ledCnt != 32'h0) ledCnt <= ledCnt - 32'h1;
            else if (awakeS && (rxDone || loadReply || loadRadio)) begin
                ledCnt <= selS ? LED_DATA : LED_CMD;
            end
            activity_indicator <= (ledCnt != 32'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    reply_flag_low_a: assert property (loadReply |=>
        !command_response_flag_n [*2]) else $error("reply sent flag high");
    radio_out_a: assert property (loadRadio |=>
        txBusy && !txIsReply && command_response_flag_n)
        else $error("air byte not sent as payload");
    exc_masked_a: assert property (!(|(excStatus & excMask)) |=>
        !exception_out) else $error("unmasked exception shown");
    payload_route_a: assert property (goodByte && selS &&
        !radioTxByte.valid |=> radioTxByte == {1'b1, $past(rxShift[7:0])})
        else $error("payload byte lost");
    cmd_route_a: assert property (goodByte && !selS &&
        !cmdByte.valid |=> cmdByte.valid) else $error("command byte lost");
    sleep_quiet_a: assert property (!awakeS |=> ctsN &&
        lowPower && !tx_amp_enable && !rx_amp_enable)
        else $error("sleep leaves block active");
    cts_busy_a: assert property (cmdByte.valid |=> ctsN)
        else $error("cts low while busy");
    empty_pending_a: assert property (radioTxByte.valid |=>
        !tx_buffer_empty) else $error("empty with byte queued");
    ack_wait_a: assert property (ackWait |=> !tx_buffer_empty)
        else $error("empty before acknowledge");
    bus_answer_a: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule

`default_nettype wire

/* hdl/rmh_pkg.sv */
// constants, types and register map of the radio module host pin block
package rmh_pkg;
    localparam int          CLK_HZ       = 50_000_000;
    localparam int          BAUD_DEF     = 115_200;
    localparam logic [15:0] BIT_CYC_DEF  = 16'(CLK_HZ / BAUD_DEF);
    localparam int          REL_HOLD_MS  = 2;    // least command-select low
    localparam logic [31:0] REL_CYC_DEF  = 32'(CLK_HZ / 1000 * REL_HOLD_MS);
    localparam int          BTN_DEB_MS   = 20;   // shortest counted press
    localparam int          BTN_LONG_MS  = 3000; // press that restores defaults
    localparam logic [31:0] BTN_DEB_DEF  = 32'(CLK_HZ / 1000 * BTN_DEB_MS);
    localparam logic [31:0] BTN_LONG_DEF = 32'(CLK_HZ / 1000 * BTN_LONG_MS);
    localparam int          LED_CMD_MS   = 200;  // flash in command mode
    localparam int          LED_DATA_MS  = 40;   // flash in data mode
    localparam logic [31:0] LED_CMD_DEF  = 32'(CLK_HZ / 1000 * LED_CMD_MS);
    localparam logic [31:0] LED_DATA_DEF = 32'(CLK_HZ / 1000 * LED_DATA_MS);
    localparam logic [3:0]  COMMAND_RESPONSE_FLAG_N_HOLD_BITS = 4'ha;
    localparam logic [3:0]  UART_FRAME_BITS = 4'ha;
    localparam logic [3:0]  PIN_RST      = 4'h7; // {button,sleep,sel,serial}
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_CMDRX    = 8'h08;
    localparam logic [7:0]  OFS_REPLY    = 8'h0c;
    localparam logic [7:0]  OFS_EXCMASK  = 8'h10;
    localparam logic [7:0]  OFS_EXCSTAT  = 8'h14;
    localparam logic [7:0]  OFS_IRQSTAT  = 8'h18;
    localparam logic [7:0]  OFS_IRQMASK  = 8'h1c;
    // control fields
    localparam int          CTRL_ACK     = 0;
    localparam int          CTRL_REL     = 1;
    localparam int          CTRL_SW_EXC  = 2;
    localparam logic [2:0]  CTRL_RST     = 3'h0;
    // exception bits
    localparam int          EXC_W        = 4;
    localparam int          EXC_RETRY    = 0;
    localparam int          EXC_FRAME    = 1;
    localparam int          EXC_OVERRUN  = 2;
    localparam int          EXC_SW       = 3;
    // interrupt event bits
    localparam int          EV_W         = 6;
    localparam int          EV_CMD       = 0;
    localparam int          EV_JOIN      = 1;
    localparam int          EV_DEFAULTS  = 2;
    localparam int          EV_RELEASE   = 3;
    localparam int          EV_EXC       = 4;
    localparam int          EV_EMPTY     = 5;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rmh_byte_t;
endpackage

/* verif/rmh_host_model.sv */
// host microcontroller model driving the serial and control pins
`timescale 1ns/1ps
`default_nettype none
module rmh_host_model #(
    parameter int BIT = 8
) (
    input  wire logic clk_sys,
    input  wire logic ctsN,
    input  wire logic serialOut,
    output logic      serialIn,
    output logic      dataModeSel,
    output logic      sleepReqN,
    output logic      button_input
);
    // idle line, awake, button released
    initial begin
        serialIn     = 1'b1;
        dataModeSel  = 1'b1;
        sleepReqN    = 1'b1;
        button_input = 1'b0;
    end
    // one 8N1 frame, lsb first, sent once the device is ready or after 200 cycles of waiting
    task automatic send(input logic m, input logic [7:0] b, output logic ok);
        logic [9:0] f;
        int n;
        f = {1'b1, b, 1'b0};
        n = 0;
        while (ctsN !== 1'b0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        ok = (n < 200);
        dataModeSel <= m;
        for (int i = 0; i < 10; i++) begin
            serialIn <= f[i];
            repeat (BIT) @(posedge clk_sys);
        end
    endtask
    // capture one frame from the device, sampled mid bit
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (serialOut !== 1'b0 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        ok = (n < 400);
        repeat (BIT + BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            b[i] = serialOut;
            repeat (BIT) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench of the host pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module tb;
    import rmh_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00, b;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, irq, serialIn, serialOut, dataModeSel, sleepReqN;
    logic button_input, ctsN, tx_buffer_empty, command_response_flag_n, ok;
    logic exception_out, rx_amp_enable, tx_amp_enable, activity_indicator;
    logic txFlush, radioRxReady, restoreDefaults, joinNetwork, lowPower;
    logic radioTxReady = 1'b0, radioTxActive = 1'b0, radioRxActive = 1'b0;
    logic radioAck = 1'b0, radioRetryFail = 1'b0, flushSeen = 1'b0;
    logic ledSeen = 1'b0, joinSeen = 1'b0, dfltSeen = 1'b0;
    rmh_byte_t radioTxByte, radioRxByte = 9'h000;
    int fail_count = 0;
    int compares = 0;
    rmh_host_pins #(.BIT_CYC(16'h8), .REL_CYC(32'h14), .BTN_DEB(32'h4),
        .BTN_LONG(32'h28), .LED_CMD(32'ha), .LED_DATA(32'h4)) dut_u (
        .clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .irq, .serialIn, .serialOut, .dataModeSel, .sleepReqN, .button_input,
        .ctsN, .tx_buffer_empty, .command_response_flag_n, .exception_out,
        .rx_amp_enable, .tx_amp_enable, .activity_indicator, .radioTxByte,
        .radioTxReady, .txFlush, .radioRxByte, .radioRxReady, .radioTxActive,
        .radioRxActive, .radioAck, .radioRetryFail, .restoreDefaults,
        .joinNetwork, .lowPower);
    rmh_host_model #(.BIT(8)) host_u (.clk_sys, .ctsN, .serialOut, .serialIn,
        .dataModeSel, .sleepReqN, .button_input);
    always #10 clk_sys = ~clk_sys;
    // radio takes air bytes away; sticky record of pulses
    always @(posedge clk_sys) begin
        if (radioRxReady && radioRxByte.valid) radioRxByte <= 9'h000;
        if (txFlush === 1'b1) flushSeen <= 1'b1;
        if (activity_indicator === 1'b1) ledSeen <= 1'b1;
        if (joinNetwork === 1'b1) joinSeen <= 1'b1;
        if (restoreDefaults === 1'b1) dfltSeen <= 1'b1;
    end
    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
        if (n >= 50) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // command byte, its interrupt and a read of it
    task automatic cmd_byte;
        bus(1, OFS_IRQMASK, 32'h1, rd);
        host_u.send(1'b0, 8'ha5, ok);
        `CHK("cts wait", 1'b1, ok)
        repeat (6) @(posedge clk_sys);
        `CHK("irq", 1'b1, irq)
        `CHK("cts busy", 1'b1, ctsN)
        bus(0, OFS_CMDRX, 0, rd);
        `CHK("cmd", 9'h1a5, rd[8:0])
        bus(1, OFS_IRQSTAT, 32'h1, rd);
        bus(0, 8'h20, 0, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("irq clr", 1'b0, irq)
        `CHK("cts free", 1'b0, ctsN)
    endtask
    // payload with acknowledge, then release trigger
    task automatic payload_ack;
        bus(1, OFS_CTRL, 32'h3, rd);
        host_u.send(1'b1, 8'h3c, ok);
        `CHK("cts wait", 1'b1, ok)
        repeat (4) @(posedge clk_sys);
        `CHK("to radio", 9'h13c, radioTxByte)
        `CHK("empty q", 1'b0, tx_buffer_empty)
        radioTxReady <= 1'b1;
        @(posedge clk_sys);
        radioTxReady <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("ack wait", 1'b0, tx_buffer_empty)
        radioAck <= 1'b1;
        @(posedge clk_sys);
        radioAck <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("empty", 1'b1, tx_buffer_empty)
        host_u.dataModeSel <= 1'b0;
        repeat (30) @(posedge clk_sys);
        `CHK("flush", 1'b1, flushSeen)
    endtask
    // reply then air payload on the one serial output
    task automatic reply_air;
        fork
            bus(1, OFS_REPLY, 32'h5a, rd);
            host_u.recv(b, ok);
        join
        `CHK("reply start", 1'b1, ok)
        `CHK("reply", 8'h5a, b)
        `CHK("command_response_flag_n low", 1'b0, command_response_flag_n)
        radioRxByte <= 9'h1c3;
        host_u.recv(b, ok);
        `CHK("air start", 1'b1, ok)
        `CHK("air", 8'hc3, b)
        `CHK("command_response_flag_n high", 1'b1, command_response_flag_n)
    endtask
    // short press joins, long press restores defaults
    task automatic button;
        host_u.button_input <= 1'b1;
        repeat (10) @(posedge clk_sys);
        host_u.button_input <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK("join", 1'b1, joinSeen)
        `CHK("no dflt", 1'b0, dfltSeen)
        host_u.button_input <= 1'b1;
        repeat (45) @(posedge clk_sys);
        host_u.button_input <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK("dflt", 1'b1, dfltSeen)
    endtask
    // exception mask, amplifiers, sleep
    task automatic misc;
        radioRetryFail <= 1'b1;
        radioRxActive <= 1'b1;
        radioTxActive <= 1'b1;
        @(posedge clk_sys);
        radioRetryFail <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("exc masked", 1'b0, exception_out)
        `CHK("rx amp", 1'b1, rx_amp_enable)
        `CHK("tx amp", 1'b1, tx_amp_enable)
        avs_byteenable <= 4'h0;
        bus(1, OFS_EXCMASK, 32'h1, rd);
        avs_byteenable <= 4'h1;
        bus(0, OFS_EXCMASK, 0, rd);
        `CHK("be0 mask", 32'h0, rd)
        bus(1, OFS_EXCMASK, 32'h1, rd);
        repeat (2) @(posedge clk_sys);
        `CHK("exc", 1'b1, exception_out)
        host_u.sleepReqN <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHK("sleep", 1'b1, lowPower)
        `CHK("cts sleep", 1'b1, ctsN)
        `CHK("led", 1'b1, ledSeen)
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        `CHK("cts rst", 1'b1, ctsN)
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cmd_byte();
        payload_ack();
        reply_air();
        button();
        misc();
        tally_and_finish();
    end
endmodule
`default_nettype wire
